/* core_supply_sequencer.sv */
// Implementation choices: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
module core_supply_sequencer #(
	parameter int unsigned SS_STEP_CYCLES = core_supply_pkg::SS_STEP_CYC,
	parameter int unsigned DEAD_CYCLES    = core_supply_pkg::DEAD_CYC
) (
	input  wire logic                                pclk,
	input  wire logic                                presetn,
	input  wire logic                                ce,
	// APB slave
	input  wire logic                                psel,
	input  wire logic                                penable,
	input  wire logic                                pwrite,
	input  wire logic [core_supply_pkg::ADDR_W-1:0]  paddr,
	input  wire logic [31:0]                         pwdata,
	output logic      [31:0]                         prdata,
	output logic                                     pready,
	output logic                                     pslverr,
	// Pins and comparator flags, all asynchronous
	input  wire logic                                enable_pin,
	input  wire logic [core_supply_pkg::VCODE_W-1:0] voltage_code_in,
	input  wire logic                                ref_above_on,
	input  wire logic                                ref_below_off,
	input  wire logic                                out_over,
	input  wire logic                                out_under,
	input  wire logic                                out_in_window,
	input  wire logic [core_supply_pkg::PHASES-1:0]  phase_req,
	input  wire logic                                power_good_in,
	// Outputs
	output logic      [core_supply_pkg::PHASES-1:0]  high_side_gate,
	output logic      [core_supply_pkg::PHASES-1:0]  low_side_gate,
	output logic      [core_supply_pkg::DAC_W-1:0]   dac_code,
	output logic                                     ref_enable,
	output logic                                     power_good_out,
	output logic                                     power_good_oe_n,
	output logic                                     irq
);
	import core_supply_pkg::*;

	// ************************************************************
	// Elaboration checks
	// ************************************************************
	if (SS_STEP_CYCLES < 1 || SS_STEP_CYCLES > 65535) begin : g_chk_ss
		$error("core_supply_sequencer: soft-start step out of counter range");
	end

	localparam logic [CNT_W-1:0] SS_RELOAD = CNT_W'(SS_STEP_CYCLES - 1);

	// ************************************************************
	// Input synchronisers
	// ************************************************************
	// All pin inputs share one two-stage chain; only stage two is read
	logic [SYNC_W-1:0] sync1;           // First stage
	logic [SYNC_W-1:0] sync2;           // Second stage, safe to use
	wire  [SYNC_W-1:0] pins = {power_good_in, phase_req, out_in_window,
		out_under, out_over, ref_below_off, ref_above_on,
		voltage_code_in, enable_pin};

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1 <= '0;
			sync2 <= '0;
		end else if (ce) begin
			sync1 <= pins;
			sync2 <= sync1;
		end
	end

	// Named views of the synchronised pins
	wire                en_s   = sync2[0];
	// Code bits arrive already pulled high when floating
	wire [VCODE_W-1:0]  code_s = sync2[5:1];
	wire                ron_s  = sync2[6];
	wire                roff_s = sync2[7];
	wire                ov_s   = sync2[8];
	wire                uv_s   = sync2[9];
	wire                win_s  = sync2[10];
	wire [PHASES-1:0]   req_s  = sync2[12:11];
	wire                pgin_s = sync2[13];

	// ************************************************************
	// Registers and state
	// ************************************************************
	seq_state_e        state;       // Sequencer state
	seq_state_e        next_state;  // Its next value
	logic              ref_ok;      // Reference lockout released
	logic              en_d;        // Enable one cycle ago
	logic              seen_low;    // Enable went low while faulted
	logic [CNT_W-1:0]  step_cnt;    // Cycles until the next step
	logic [CNT_W-1:0]  trans_per;   // Transition step period, cycles
	logic [N_EV-1:0]   irq_status;  // Sticky events
	logic [N_EV-1:0]   irq_mask;    // Event enables
	logic              pg;          // Power-good level, high is good
	logic              settled_d;   // Target reached, delayed

	// ************************************************************
	// Code decode and step decisions
	// ************************************************************
	// Linear decode; the off code 1F decodes to VCODE_BASE, like a normal top code
	wire [DAC_W-1:0] nominal   = VCODE_BASE + {{(DAC_W-VCODE_W){1'b0}}, ~code_s};
	wire             code_off  = (code_s == VCODE_OFF);
	wire             at_target = (dac_code == nominal);
	wire             tick      = (step_cnt == '0);
	wire             st_ramp   = (state == ST_RAMP);
	wire             st_run    = (state == ST_RUN);
	wire             st_fault  = (state == ST_FAULT);
	wire             active    = st_ramp | st_run;
	wire             step_up   = tick & (dac_code < nominal) & active;
	wire             step_dn   = tick & (dac_code > nominal) & st_run;
	// Overvoltage guarded in ramp and run; undervoltage only once up to level
	wire             fault_hit = (active & ov_s) | (st_run & uv_s);
	// Good only when settled, in window and error free
	wire             next_pg   = st_run & at_target & win_s;
	wire             settled   = st_run & at_target;

	// ************************************************************
	// Reference lockout with hysteresis
	// ************************************************************
	// Two comparators give the two thresholds; reference off with enable
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ref_ok <= 1'b0;
		end else if (ce) begin
			if (!en_s) begin
				ref_ok <= 1'b0;
			end else if (roff_s) begin
				ref_ok <= 1'b0;
			end else if (ron_s) begin
				ref_ok <= 1'b1;
			end
		end
	end

	// ************************************************************
	// Sequencer next state
	// ************************************************************
	always_comb begin
		next_state = state;
		case (state)
			ST_OFF: begin
				// Rising enable starts the sequence
				if (en_s && !en_d) begin
					next_state = ST_WAIT;
				end
			end
			ST_WAIT: begin
				if (!en_s) begin
					next_state = ST_OFF;
				end else if (ref_ok) begin
					next_state = ST_RAMP;
				end
			end
			ST_RAMP: begin
				if (!en_s) begin
					next_state = ST_OFF;
				end else if (!ref_ok) begin
					next_state = ST_WAIT;
				end else if (fault_hit) begin
					next_state = ST_FAULT;
				end else if (at_target) begin
					next_state = ST_RUN;
				end
			end
			ST_RUN: begin
				if (!en_s) begin
					next_state = ST_OFF;
				end else if (!ref_ok) begin
					next_state = ST_WAIT;
				end else if (fault_hit) begin
					next_state = ST_FAULT;
				end
			end
			ST_FAULT: begin
				// Held until enable goes low and then high again
				if (seen_low && en_s) begin
					next_state = ST_WAIT;
				end
			end
			default: begin
				next_state = ST_OFF;
			end
		endcase
	end

	// State register and edge memory
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= ST_OFF;
			en_d  <= 1'b0;
		end else if (ce) begin
			state <= next_state;
			en_d  <= en_s;
		end
	end

	// Remembers the low half of the enable toggle while faulted
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			seen_low <= 1'b0;
		end else if (ce) begin
			if (!st_fault) begin
				seen_low <= 1'b0;
			end else if (!en_s) begin
				seen_low <= 1'b1;
			end
		end
	end

	// ************************************************************
	// Target stepping and step counter
	// ************************************************************
	// Ramp uses the soft-start period, code changes the programmed one.
	// At target the counter sits reloaded, so the first step after a
	// code change comes one full period later, never early.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dac_code <= '0;
			step_cnt <= '0;
		end else if (ce) begin
			if (!active) begin
				dac_code <= '0;
				step_cnt <= SS_RELOAD;
			end else if (step_up || step_dn) begin
				dac_code <= step_up ? dac_code + 1'b1 : dac_code - 1'b1;
				step_cnt <= st_ramp ? SS_RELOAD : trans_per - 1'b1;
			end else if (at_target) begin
				step_cnt <= st_ramp ? SS_RELOAD : trans_per - 1'b1;
			end else if (!tick) begin
				step_cnt <= step_cnt - 1'b1;
			end
		end
	end

	// ************************************************************
	// Gate drivers, one per phase
	// ************************************************************
	// Off code or shutdown stops switching; fault forces the crowbar
	wire gates_run = active & ~code_off;

	genvar ph;
	for (ph = 0; ph < PHASES; ph++) begin : g_phase
		gate_deadtime #(
			.DEAD_CYCLES (DEAD_CYCLES)
		) u_drv (
			.pclk           (pclk),
			.presetn        (presetn),
			.ce             (ce),
			.run            (gates_run),
			.fault_mode     (st_fault),
			.req            (req_s[ph]),
			.high_side_gate (high_side_gate[ph]),
			.low_side_gate  (low_side_gate[ph])
		);
	end

	// ************************************************************
	// Power-good and reference enable
	// ************************************************************
	// Open drain: value and enable come from the same flop, so the
	// pin is pulled low exactly when power is not good
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pg         <= 1'b0;
			ref_enable <= 1'b0;
			settled_d  <= 1'b0;
		end else if (ce) begin
			pg         <= next_pg;
			ref_enable <= en_s;
			settled_d  <= settled;
		end
	end

	assign power_good_out  = pg;
	assign power_good_oe_n = pg;

	// ************************************************************
	// Events and interrupt
	// ************************************************************
	wire [N_EV-1:0] ev;
	assign ev[EV_FAULT]   = (next_state == ST_FAULT) & ~st_fault;
	assign ev[EV_PG_RISE] = next_pg & ~pg;
	assign ev[EV_PG_FALL] = ~next_pg & pg;
	assign ev[EV_LOCKOUT] = ref_ok & en_s & roff_s;
	assign ev[EV_SETTLED] = settled & ~settled_d;

	// ************************************************************
	// APB decode
	// ************************************************************
	// One wait state: pready rises in the second access cycle
	wire acc      = psel & penable;
	wire rd_load  = acc & ~pready;
	wire wr_now   = acc & pready & pwrite;
	wire hit_tr   = (paddr == OFF_TRANS);
	wire hit_st   = (paddr == OFF_STATUS);
	wire hit_is   = (paddr == OFF_IRQ_ST);
	wire hit_im   = (paddr == OFF_IRQ_MK);
	wire hit_tg   = (paddr == OFF_TARGET);
	wire unmapped = ~(hit_tr | hit_st | hit_is | hit_im | hit_tg);
	wire [N_EV-1:0] w1c = (wr_now & hit_is) ? pwdata[N_EV-1:0] : '0;

	wire [31:0] status_word = {22'h000000, pgin_s, code_off, ref_ok,
		pg, st_fault, state};
	wire [31:0] target_word = {11'h000, code_s, nominal, dac_code};
	wire [31:0] rd_mux =
		hit_tr ? {16'h0000, trans_per} :
		hit_st ? status_word :
		hit_is ? {27'h0000000, irq_status} :
		hit_im ? {27'h0000000, irq_mask} :
		hit_tg ? target_word : 32'h00000000;

	// Bus handshake, read data and error flag
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= '0;
		end else if (ce) begin
			pready  <= rd_load;
			pslverr <= rd_load & unmapped;
			if (rd_load) begin
				prdata <= pwrite ? 32'h00000000 : rd_mux;
			end
		end
	end

	// Writable registers; a zero period would wrap, so it becomes one
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			trans_per <= TRANS_RST;
			irq_mask  <= '0;
		end else if (ce) begin
			if (wr_now && hit_tr) begin
				trans_per <= (pwdata[CNT_W-1:0] == '0) ? CNT_W'(1) : pwdata[CNT_W-1:0];
			end
			if (wr_now && hit_im) begin
				irq_mask <= pwdata[N_EV-1:0];
			end
		end
	end

	// Sticky events: a new event beats a clear in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_status <= '0;
			irq <= 1'b0;
		end else if (ce) begin
			irq_status <= (irq_status & ~w1c) | ev;
			irq        <= |(irq_status & irq_mask);
		end
	end

	// Live power-good pin level is shown in the status word
	// Read back only; no logic acts on the pin level itself

endmodule

/* core_supply_pkg.sv */
// How it works
// - Enable above 1.600 V, drop below 1.584 V
// - Enable low: gates low, reference off, no good; a latched fault keeps the low sides on
// - Off code: only gates held low
// - Rising enable starts; switching waits for reference
// - Startup ramps one 25 mV step per 50 us
// - Over/undervoltage: high off, low on, no good
// - Fault latched until reset or enable high-low-high
// - Five-bit code decodes target; only code 1F disables
// - Code bits float high by internal pull-up
// - Code changes walk target in 25 mV steps
// - Transition step time follows timing resistor; here set by the transition period register, reset to the 100 kOhm value
// - Good low outside 12.5 percent window
// - Good low in shutdown, lockout and ramp
// - Complementary drives with fixed dead time
package core_supply_pkg;

	// ************************************************************
	// Clock and timing
	// ************************************************************
	localparam int unsigned CLK_PERIOD_NS = 10;       // 100 MHz pclk
	localparam int unsigned SS_STEP_US    = 50;       // Soft-start step time
	localparam int unsigned SS_STEP_CYC   = (SS_STEP_US * 1000) / CLK_PERIOD_NS;
	localparam int unsigned SLEW_STEP_MV  = 25;       // One target step
	localparam int unsigned RTIME_COEF    = 521;      // Ohm times V per us
	localparam int unsigned RTIME_OHM     = 100000;   // Default timing resistor
	// Step time in ns is step(mV) * R / 521
	localparam int unsigned TRANS_STEP_NS = (SLEW_STEP_MV * RTIME_OHM) / RTIME_COEF;
	localparam int unsigned TRANS_STEP_CYC = (TRANS_STEP_NS / CLK_PERIOD_NS) > 0 ?
		(TRANS_STEP_NS / CLK_PERIOD_NS) : 1;
	localparam int unsigned DEAD_NS       = 30;       // Gate dead time
	localparam int unsigned DEAD_CYC      = (DEAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ************************************************************
	// Widths and code decode
	// ************************************************************
	localparam int unsigned VCODE_W   = 5;            // Voltage code width
	localparam int unsigned DAC_W     = 8;            // Target in 25 mV units
	localparam int unsigned CNT_W     = 16;           // Step counter width
	localparam int unsigned PHASES    = 2;            // Power phases
	localparam int unsigned SYNC_W    = 14;           // Synchronised pin bits
	localparam logic [VCODE_W-1:0] VCODE_OFF  = 5'h1F;   // Output-disable code
	localparam logic [DAC_W-1:0]   VCODE_BASE = 8'h20;   // Target for top code
	localparam logic [CNT_W-1:0]   TRANS_RST  = CNT_W'(TRANS_STEP_CYC);

	// ************************************************************
	// Register map (byte addresses)
	// ************************************************************
	localparam int unsigned ADDR_W = 8;
	localparam logic [ADDR_W-1:0] OFF_TRANS  = 8'h00;  // Transition step cycles
	localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h04;  // Live state
	localparam logic [ADDR_W-1:0] OFF_IRQ_ST = 8'h08;  // Sticky events, W1C
	localparam logic [ADDR_W-1:0] OFF_IRQ_MK = 8'h0C;  // Event mask
	localparam logic [ADDR_W-1:0] OFF_TARGET = 8'h10;  // Target and code

	// ************************************************************
	// Event bits
	// ************************************************************
	localparam int unsigned N_EV        = 5;
	localparam int unsigned EV_FAULT    = 0;
	localparam int unsigned EV_PG_RISE  = 1;
	localparam int unsigned EV_PG_FALL  = 2;
	localparam int unsigned EV_LOCKOUT  = 3;
	localparam int unsigned EV_SETTLED  = 4;

	// ************************************************************
	// Sequencer states
	// ************************************************************
	typedef enum logic [4:0] {
		ST_OFF   = 5'h01,
		ST_WAIT  = 5'h02,
		ST_RAMP  = 5'h04,
		ST_RUN   = 5'h08,
		ST_FAULT = 5'h10
	} seq_state_e;

endpackage

/* gate_deadtime.sv */
`timescale 1ns/1ps
// One phase of complementary gate drive with break-before-make
module gate_deadtime #(
	parameter int unsigned DEAD_CYCLES = 3
) (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic ce,
	input  wire logic run,          // Switching allowed
	input  wire logic fault_mode,   // Crowbar: high off, low on
	input  wire logic req,          // Loop asks for high side
	output logic      high_side_gate,
	output logic      low_side_gate
);

	// ************************************************************
	// Wanted states and dead-time counter
	// ************************************************************
	localparam int unsigned DW = $clog2(DEAD_CYCLES + 1);
	localparam logic [DW-1:0] DEAD_LD = DW'(DEAD_CYCLES);

	logic [DW-1:0] dead;            // Cycles left with both off
	wire hs_want = run & ~fault_mode & req;
	wire ls_want = fault_mode | (run & ~req);

	if (DEAD_CYCLES < 1) begin : g_chk
		$error("gate_deadtime: dead time must be at least one cycle");
	end

	// Turn-off is immediate; turn-on waits for the dead time to run out
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			high_side_gate <= 1'b0;
			low_side_gate  <= 1'b0;
			dead           <= '0;
		end else if (ce) begin
			if (high_side_gate && !hs_want) begin
				high_side_gate <= 1'b0;
				dead           <= DEAD_LD;
			end else if (low_side_gate && !ls_want) begin
				low_side_gate <= 1'b0;
				dead          <= DEAD_LD;
			end else if (dead != '0) begin
				dead <= dead - 1'b1;
			end else if (hs_want && !low_side_gate) begin
				high_side_gate <= 1'b1;
			end else if (ls_want && !high_side_gate) begin
				low_side_gate <= 1'b1;
			end
		end
	end

endmodule

/* core_supply_props.sv */
`timescale 1ns/1ps
// ************************************************
// Pin-level checker for the supply sequencer
// ************************************************
module core_supply_props
	import core_supply_pkg::*;
#(
	parameter int unsigned SS_STEP_CYCLES = 20,
	parameter int unsigned DEAD_CYCLES    = 3
) (
	input wire logic               pclk,
	input wire logic               presetn,
	input wire logic               psel,
	input wire logic               penable,
	input wire logic               pready,
	input wire logic               enable_pin,
	input wire logic [VCODE_W-1:0] voltage_code_in,
	input wire logic               out_over,
	input wire logic               out_in_window,
	input wire logic [PHASES-1:0]  high_side_gate,
	input wire logic [PHASES-1:0]  low_side_gate,
	input wire logic [DAC_W-1:0]   dac_code,
	input wire logic               ref_enable,
	input wire logic               power_good_out
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Bus steps and crowbar steps
	sequence s_setup; psel && !penable; endsequence
	sequence s_wait; psel && penable && !pready; endsequence
	sequence s_trip; out_over && power_good_out; endsequence
	sequence s_crow; high_side_gate == '0 && low_side_gate == '1 && !power_good_out; endsequence
	a_apb_answer: assert property (s_setup ##1 s_wait |=> pready)
		else $error("bus answer not on second access edge");
	a_no_shoot: assert property ((high_side_gate & low_side_gate) == '0)
		else $error("both switches of a phase on");
	a_dead_gap: assert property ($rose(high_side_gate[0]) |-> !$past(low_side_gate[0], DEAD_CYCLES))
		else $error("high side on without dead time");
	a_pg_ref: assert property (power_good_out |-> ref_enable)
		else $error("good high with reference off");
	a_dac_step: assert property ($changed(dac_code) |->
		(dac_code - $past(dac_code)) inside {8'h01, 8'hFF} || dac_code == 8'h00)
		else $error("target moved by more than one step");
	a_crowbar: assert property (s_trip |-> ##[1:12] s_crow)
		else $error("overvoltage not crowbarred");
	a_pg_window: assert property ((!out_in_window) [*5] |-> !power_good_out)
		else $error("good high outside window");
	a_code_off: assert property ((voltage_code_in == VCODE_OFF) [*6] |-> high_side_gate == '0)
		else $error("high side on under off code");
	a_en_low: assert property ((!enable_pin) [*6] |->
		!ref_enable && !power_good_out && high_side_gate == '0)
		else $error("enable low but stage still on");
endmodule
bind core_supply_sequencer core_supply_props #(.SS_STEP_CYCLES(SS_STEP_CYCLES),
	.DEAD_CYCLES(DEAD_CYCLES)) u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pready(pready), .enable_pin(enable_pin),
	.voltage_code_in(voltage_code_in), .out_over(out_over), .out_in_window(out_in_window),
	.high_side_gate(high_side_gate), .low_side_gate(low_side_gate), .dac_code(dac_code),
	.ref_enable(ref_enable), .power_good_out(power_good_out));

/* core_supply_stage.sv */
`timescale 1ns/1ps
// ************************************************
// Power stage, reference and good-pin model
// ************************************************
module core_supply_stage (
	input  wire logic  pclk,
	input  wire logic  ref_enable,
	input  wire logic  power_good_oe_n,
	input  wire logic  droop,
	output logic       ref_above_on,
	output logic       ref_below_off,
	output logic       out_in_window,
	output logic [1:0] phase_req,
	output logic       power_good_in
);
	logic [3:0] ref_lvl = 4'h0;  // Reference level, slow RC
	logic [4:0] pwm     = 5'h00; // Switching period count
	// Reference charges while on and bleeds away when off
	always @(posedge pclk) begin
		pwm <= pwm + 5'h01;
		if (ref_enable && ref_lvl != 4'hF)
			ref_lvl <= ref_lvl + 4'h1;
		else if (!ref_enable && ref_lvl != 4'h0)
			ref_lvl <= ref_lvl - 4'h1;
	end
	// Gap between thresholds so both flags never stand together
	assign ref_above_on  = (ref_lvl == 4'hF);
	assign ref_below_off = (ref_lvl < 4'hE);
	// Output tracks target unless the bench pulls it away
	assign out_in_window = !droop;
	// Phases half a period apart
	assign phase_req     = {~pwm[4], pwm[4]};
	// Open-drain pin with pull-up
	assign power_good_in = power_good_oe_n;
endmodule

/* test_core_supply_sequencer.sv */
`timescale 1ns/1ps
module test_core_supply_sequencer;
	import core_supply_pkg::*;
	localparam int unsigned SS = 20; // Short soft-start step
	localparam int unsigned TR = 4;  // Short transition step
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
	logic        enable_pin, out_over, droop, ref_enable, ref_above_on, ref_below_off;
	logic        out_in_window, power_good_in, power_good_out, power_good_oe_n, out_under;
	logic [7:0]  paddr, dac_code;
	logic [31:0] pwdata, prdata;
	logic [4:0]  code, code2, voltage_code_in;
	logic [1:0]  phase_req, high_side_gate, low_side_gate;
	logic [32:0] q_exp[$], q_msk[$]; // Expected reads, oldest first
	int          n_mismatch, checks, cyc, t0;
	core_supply_sequencer #(.SS_STEP_CYCLES(SS), .DEAD_CYCLES(2)) dut_u (.pclk(pclk),
		.presetn(presetn), .ce(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.enable_pin(enable_pin), .voltage_code_in(voltage_code_in),
		.ref_above_on(ref_above_on), .ref_below_off(ref_below_off), .out_over(out_over),
		.out_under(out_under), .out_in_window(out_in_window), .phase_req(phase_req),
		.power_good_in(power_good_in), .high_side_gate(high_side_gate),
		.low_side_gate(low_side_gate), .dac_code(dac_code), .ref_enable(ref_enable),
		.power_good_out(power_good_out), .power_good_oe_n(power_good_oe_n), .irq(irq));
	core_supply_stage stage_u (.pclk(pclk), .ref_enable(ref_enable),
		.power_good_oe_n(power_good_oe_n), .droop(droop), .ref_above_on(ref_above_on),
		.ref_below_off(ref_below_off), .out_in_window(out_in_window),
		.phase_req(phase_req), .power_good_in(power_good_in));
	// ************************************************
	// Clock, timeout and read monitor
	// ************************************************
	always #5 pclk = ~pclk;
	// Cycle count, also used to time steps
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_mismatch++;
			end_sim();
		end
	end
	// Each finished read is matched to the oldest note
	always @(posedge pclk) begin
		if (psel && penable && pready && !pwrite)
			chk({pslverr, prdata} & q_msk.pop_front(), q_exp.pop_front());
	end
	// ************************************************
	// Tasks
	// ************************************************
	task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
		checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("ERROR %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	// Request held until pready seen high
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk iff pready);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [32:0] e, input logic [32:0] m);
		q_exp.push_back(e);
		q_msk.push_back(m);
		apb(1'b0, a, 32'h0);
	endtask
	// Nominal target of a code, 25 mV units
	function automatic logic [7:0] nom(input logic [4:0] c);
		return 8'h20 + {3'h0, ~c};
	endfunction
	task automatic ticks(input int n);
		repeat (n) @(posedge pclk);
	endtask
	task automatic wait_pg;
		while (!power_good_out) @(posedge pclk);
	endtask
	task automatic end_sim;
		$display("mismatches %0d checks %0d", n_mismatch, checks);
		if (n_mismatch == 0 && checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// ************************************************
	// Main sequence
	// ************************************************
	initial begin
		void'($urandom(32'h49618C69));
		{pclk, presetn, psel, penable, pwrite, enable_pin, out_over, out_under, droop} = 9'h000;
		{paddr, pwdata, cyc, n_mismatch, checks} = '0;
		// Bit 3 kept clear: neither code is the off code, and they differ by 4 steps
		code = 5'($urandom) & 5'h17;
		code2 = code ^ 5'h04;
		voltage_code_in = code;
		ticks(3);
		presetn <= 1'b1;
		rd(OFF_TRANS, 33'h0_0000_01DF, 33'h1_0000_FFFF);
		rd(OFF_IRQ_MK, 33'h0, 33'h1_0000_001F);
		rd(OFF_STATUS, 33'h1, 33'h1_0000_001F);
		rd(8'h40, 33'h1_0000_0000, 33'h1_FFFF_FFFF);
		apb(1'b1, OFF_TRANS, 32'h0);
		rd(OFF_TRANS, 33'h1, 33'h1_0000_FFFF);
		apb(1'b1, OFF_TRANS, TR);
		apb(1'b1, OFF_IRQ_MK, 32'h1F);
		$display("reset and registers done");
		enable_pin <= 1'b1;
		while (dac_code != 8'h01) @(posedge pclk);
		t0 = cyc;
		while (dac_code != 8'h02) @(posedge pclk);
		chk(33'(cyc - t0), 33'(SS));
		chk(33'(power_good_out), 33'h0);
		wait_pg();
		rd(OFF_STATUS, 33'h2C8, 33'h1_0000_03FF);
		rd(OFF_TARGET, 33'({code, nom(code), nom(code)}), 33'h1_001F_FFFF);
		rd(OFF_IRQ_ST, 33'h2, 33'h1_0000_0002);
		chk(33'(irq), 33'h1);
		apb(1'b1, OFF_IRQ_ST, 32'h1F);
		ticks(3);
		chk(33'(irq), 33'h0);
		droop <= 1'b1;
		ticks(6);
		chk(33'(power_good_out), 33'h0);
		droop <= 1'b0;
		$display("startup done");
		voltage_code_in <= code2;
		while (dac_code == nom(code)) @(posedge pclk);
		t0 = cyc;
		while (dac_code != nom(code2)) @(posedge pclk);
		chk(33'(cyc - t0), 33'(3 * TR));
		rd(OFF_TARGET, 33'({code2, nom(code2), nom(code2)}), 33'h1_001F_FFFF);
		voltage_code_in <= 5'h1F;
		ticks(10);
		chk(33'({high_side_gate, low_side_gate, ref_enable}), 33'h1);
		rd(OFF_STATUS, 33'h100, 33'h1_0000_0100);
		voltage_code_in <= code2;
		wait_pg();
		$display("code change done");
		out_over <= 1'b1;
		ticks(12);
		chk(33'({high_side_gate, low_side_gate, power_good_out}), 33'h06);
		out_over <= 1'b0;
		rd(OFF_STATUS, 33'h30, 33'h1_0000_023F);
		enable_pin <= 1'b0;
		ticks(8);
		chk(33'(low_side_gate), 33'h3);
		enable_pin <= 1'b1;
		ticks(8);
		rd(OFF_STATUS, 33'h0, 33'h1_0000_0020);
		wait_pg();
		out_under <= 1'b1;
		ticks(12);
		chk(33'({high_side_gate, low_side_gate, power_good_out}), 33'h06);
		out_under <= 1'b0;
		$display("fault done");
		// Toggle out of the latched fault, then shut down from the wait state
		enable_pin <= 1'b0;
		ticks(8);
		enable_pin <= 1'b1;
		ticks(4);
		enable_pin <= 1'b0;
		ticks(8);
		chk(33'({high_side_gate, low_side_gate, ref_enable, power_good_out, dac_code}), 33'h0);
		$display("shutdown done");
		end_sim();
	end
endmodule
